// ### bench/fps_flash_model.sv
// Purpose: flash device model
// Assumes: no clock; commands taken on the rising write strobe
// Notes: fault knobs set by the bench
module fps_flash_model
    import fps_pkg::*;
(
    input wire logic [23:0] addr_in,
    input wire logic [7:0] dq_in,
    input wire logic ce_n_in,
    input wire logic oe_n_in,
    input wire logic we_n_in,
    input wire logic rp_n_in,
    output logic [7:0] dq_out,
    output logic dq_oe_out,
    output logic status_pin_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:255]; // Small array on the low address byte
    logic [7:0] sr = 8'h80; // Status bits, ready kept apart
    logic [7:0] shown = 8'h00; // Value latched at read strobe fall
    logic [1:0] mode = 2'h0; // 0 array, 1 status, 2 extended
    logic setup = 1'b0; // Program setup seen
    logic ready = 1'b1; // Internal machine idle
    logic volt_bad = 1'b0; // Fault and state knobs
    logic locked = 1'b0;
    logic prog_fail = 1'b0;
    logic erasing = 1'b0;
    logic buf_free = 1'b1;
    // Busy for a while, then ready again
    task automatic go_busy();
        ready = 1'b0;
        fork
            #400 ready = 1'b1;
        join_none
    endtask : go_busy
    // Commands; reset pin restores read array
    always @(posedge we_n_in or negedge rp_n_in) begin
        if (!rp_n_in) begin
            mode = 2'h0;
            sr = 8'h80;
            setup = 1'b0;
            ready = 1'b1;
        end else if (!ce_n_in && setup) begin
            setup = 1'b0;
            mode = 2'h1;
            if (volt_bad) sr[FPS_SR_VOLT_ERR] = 1'b1;
            else if (locked) sr[FPS_SR_PROT_ERR] = 1'b1;
            else begin
                sr[FPS_SR_PROG_ERR] = sr[FPS_SR_PROG_ERR] | prog_fail;
                if (!prog_fail) mem[addr_in[7:0]] = dq_in;
                go_busy();
            end
        end else if (!ce_n_in) begin
            case (dq_in)
                FPS_CMD_PROG_SETUP: setup = 1'b1;
                FPS_CMD_READ_ARRAY: mode = 2'h0;
                FPS_CMD_READ_STATUS: mode = 2'h1;
                FPS_CMD_CLEAR_STATUS: sr = sr & 8'he5;
                FPS_CMD_BUF_WRITE: mode = 2'h2;
                FPS_CMD_SUSPEND: begin
                    mode = 2'h1;
                    sr[FPS_SR_SUSP] = erasing;
                    if (erasing) go_busy();
                end
                FPS_CMD_RESUME: sr[FPS_SR_SUSP] = 1'b0;
                default: ;
            endcase
        end
    end
    // Latch shown value on read strobe fall
    always @(negedge oe_n_in) begin
        case (mode)
            2'h1: shown = {ready, sr[6:0]} | 8'h05;
            2'h2: shown = {buf_free, 7'h35};
            default: shown = mem[addr_in[7:0]];
        endcase
    end
    assign dq_oe_out = rp_n_in && !ce_n_in && !oe_n_in;
    assign dq_out = dq_oe_out ? shown : ~shown; // Released bus drifts
    assign status_pin_out = ready || !rp_n_in;
endmodule : fps_flash_model

// ### bench/fps_host_assertions.sv
// Purpose: flash pin protocol checks
// Assumes: one clock domain
// Notes: bound to fps_host from the testbench top file
module fps_host_checker
    import fps_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic system_power_ok_in,
    input wire logic [23:0] flash_addr_out,
    input wire logic [7:0] flash_data_out,
    input wire logic flash_data_oe_out,
    input wire logic chip_enable_zero_n_out,
    input wire logic flash_oe_n_out,
    input wire logic flash_we_n_out,
    input wire logic reset_powerdown_n_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic setup_seen; // Last write was setup
    logic [23:0] setup_addr; // Address of that write
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);
    // Track setup writes
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            setup_seen <= 1'b0;
            setup_addr <= 24'h0;
        end else if ($fell(flash_we_n_out)) begin
            setup_seen <= !setup_seen && flash_data_out == FPS_CMD_PROG_SETUP;
            setup_addr <= flash_addr_out;
        end
    end
    property p_wr_pins;
        !flash_we_n_out |-> !chip_enable_zero_n_out && flash_data_oe_out && flash_oe_n_out;
    endproperty
    a_wr_pins: assert property (p_wr_pins) else $error("write without select or drive");
    property p_rd_pins;
        !flash_oe_n_out |-> !chip_enable_zero_n_out && !flash_data_oe_out;
    endproperty
    a_rd_pins: assert property (p_rd_pins) else $error("read while host drives bus");
    property p_we_width;
        $fell(flash_we_n_out) |=> !flash_we_n_out ##1 flash_we_n_out;
    endproperty
    a_we_width: assert property (p_we_width) else $error("write strobe not two cycles");
    property p_oe_width;
        $fell(flash_oe_n_out) |=> !flash_oe_n_out ##1 flash_oe_n_out;
    endproperty
    a_oe_width: assert property (p_oe_width) else $error("read strobe not two cycles");
    property p_wr_stable;
        !flash_we_n_out && !$fell(flash_we_n_out) |-> $stable({flash_addr_out, flash_data_out});
    endproperty
    a_wr_stable: assert property (p_wr_stable) else $error("write bus moved");
    property p_prog_addr;
        $fell(flash_we_n_out) && setup_seen |-> flash_addr_out == setup_addr;
    endproperty
    a_prog_addr: assert property (p_prog_addr) else $error("program data elsewhere");
    property p_power_loss;
        !system_power_ok_in [*6] |-> !reset_powerdown_n_out;
    endproperty
    a_power_loss: assert property (p_power_loss) else $error("reset pin high, power bad");
    property p_rp_wait;
        $rose(reset_powerdown_n_out) |-> $past(system_power_ok_in, 16) && system_power_ok_in;
    endproperty
    a_rp_wait: assert property (p_rp_wait) else $error("reset pin rose too early");
    property p_blocked;
        !reset_powerdown_n_out |-> flash_we_n_out && flash_oe_n_out;
    endproperty
    a_blocked: assert property (p_blocked) else $error("strobe during flash reset");
endmodule : fps_host_checker

// ### bench/testbench.sv
// Purpose: self-checking bench for the flash host controller
// Assumes: flash model on the pins
// Notes: one task per scenario
module testbench;
    import fps_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [3:0] reg_addr_in = 4'h0;
    logic [31:0] reg_wdata_in = 32'h0;
    logic reg_write_in = 1'b0;
    logic reg_read_in = 1'b0;
    logic system_power_ok_in = 1'b1;
    logic [31:0] reg_rdata_out, rv, ist;
    logic [23:0] flash_addr_out;
    logic [7:0] flash_data_out, flash_data_in, model_dq;
    logic irq_out, flash_data_oe_out, chip_enable_zero_n_out, flash_oe_n_out;
    logic flash_we_n_out, reset_powerdown_n_out, status_pin_in, model_oe;
    int fails = 0;
    int check_count = 0;
    always #25 sys_clk_in = ~sys_clk_in;
    assign flash_data_in = flash_data_oe_out ? flash_data_out : model_dq; // Shared bus
    fps_host u_fps_host (.*);
    fps_flash_model u_fps_flash_model (.addr_in(flash_addr_out), .dq_in(flash_data_in),
        .ce_n_in(chip_enable_zero_n_out), .oe_n_in(flash_oe_n_out), .we_n_in(flash_we_n_out),
        .rp_n_in(reset_powerdown_n_out), .dq_out(model_dq), .dq_oe_out(model_oe),
        .status_pin_out(status_pin_in));
    task automatic print_verdict();
        $display("Checks %0d, errors %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : print_verdict
    task automatic check(input logic [31:0] got, input logic [31:0] expv);
        check_count++;
        if (got !== expv) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, expv);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_write_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_write_in <= 1'b0;
    endtask : wr
    // Data stands the cycle after
    task automatic rd(input logic [3:0] a);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_read_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_read_in <= 1'b0;
        @(negedge sys_clk_in);
        rv = reg_rdata_out;
    endtask : rd
    task automatic wait_idle();
        for (int i = 0; i < 3000; i++) begin
            rd(FPS_REG_CTRL);
            if (rv[3] === 1'b1) return;
        end
        fails++;
        $display("Error at %0t: controller stuck busy", $time);
        print_verdict();
    endtask : wait_idle
    // Run an op, await its event, read status
    task automatic run_op(input logic [2:0] op);
        wait_idle();
        wr(FPS_REG_IRQ_STAT, 32'h7);
        wr(FPS_REG_CTRL, {29'h0, op});
        rv = 32'h0;
        for (int i = 0; i < 3000 && rv[2:0] === 3'h0; i++) begin
            rd(FPS_REG_IRQ_STAT);
        end
        ist = rv;
        check({31'h0, |ist[2:0]}, 32'h1);
        if (ist[2:0] === 3'h0) print_verdict();
        wait_idle();
        rd(FPS_REG_STATUS);
    endtask : run_op
    task automatic t_reset();
        rd(FPS_REG_IRQ_MASK);
        check(rv, {24'h0, FPS_MASK_RESET});
        rd(FPS_REG_STATUS);
        check({24'h0, rv[7:0]}, {24'h0, FPS_STATUS_RESET});
        rd(4'h8);
        check(rv, 32'h0);
        check({31'h0, irq_out}, 32'h0);
    endtask : t_reset
    task automatic t_program();
        wr(FPS_REG_IRQ_MASK, 32'h1);
        wr(FPS_REG_ADDR, 32'h12);
        wr(FPS_REG_WDATA, 32'ha5);
        run_op(FPS_OP_PROGRAM);
        check({24'h0, u_fps_flash_model.mem[8'h12]}, 32'ha5);
        check({24'h0, rv[7:0]}, 32'h80);
        check({31'h0, irq_out}, 32'h1);
        wr(FPS_REG_IRQ_STAT, 32'h1);
        @(negedge sys_clk_in);
        check({31'h0, irq_out}, 32'h0);
        wr(FPS_REG_IRQ_MASK, 32'h0);
        run_op(FPS_OP_READ);
        check({31'h0, irq_out}, 32'h0);
        rd(FPS_REG_RDATA);
        check(rv, 32'ha5);
    endtask : t_program
    // Errors pile up until cleared
    task automatic t_errors();
        logic [7:0] expv;
        expv = 8'h80;
        for (int k = 0; k < 3; k++) begin
            u_fps_flash_model.prog_fail = (k == 0);
            u_fps_flash_model.volt_bad = (k == 1);
            u_fps_flash_model.locked = (k == 2);
            expv = expv | (k == 0 ? 8'h10 : k == 1 ? 8'h08 : 8'h02);
            wr(FPS_REG_ADDR, 32'h20 + k);
            run_op(FPS_OP_PROGRAM);
            check({24'h0, rv[7:0]}, {24'h0, expv});
            check({31'h0, ist[FPS_IRQ_ERROR]}, 32'h1);
        end
        u_fps_flash_model.locked = 1'b0;
        run_op(FPS_OP_CLEAR);
        run_op(FPS_OP_PROGRAM);
        check({24'h0, rv[7:0]}, 32'h80);
    endtask : t_errors
    task automatic t_buffer();
        for (int k = 0; k < 2; k++) begin
            u_fps_flash_model.buf_free = k[0];
            run_op(FPS_OP_BUF_QUERY);
            check({24'h0, rv[15:8]}, {24'h0, k[0], 7'h0});
        end
    endtask : t_buffer
    task automatic t_suspend();
        u_fps_flash_model.erasing = 1'b1;
        run_op(FPS_OP_SUSPEND);
        check({31'h0, rv[FPS_SR_SUSP]}, 32'h1);
        check({31'h0, ist[FPS_IRQ_SUSP]}, 32'h1);
        wr(FPS_REG_ADDR, 32'h30);
        wr(FPS_REG_WDATA, 32'h3c);
        run_op(FPS_OP_PROGRAM);
        check({24'h0, u_fps_flash_model.mem[8'h30]}, 32'h3c);
        run_op(FPS_OP_RESUME);
        check({31'h0, u_fps_flash_model.sr[FPS_SR_SUSP]}, 32'h0);
        u_fps_flash_model.erasing = 1'b0;
        run_op(FPS_OP_SUSPEND);
        check({31'h0, rv[FPS_SR_SUSP]}, 32'h0);
    endtask : t_suspend
    task automatic t_power();
        @(posedge sys_clk_in);
        system_power_ok_in <= 1'b0;
        for (int i = 0; i < 50 && reset_powerdown_n_out !== 1'b0; i++) begin
            @(posedge sys_clk_in);
        end
        check({31'h0, reset_powerdown_n_out}, 32'h0);
        check({30'h0, u_fps_flash_model.mode}, 32'h0);
        system_power_ok_in <= 1'b1;
        wait_idle();
    endtask : t_power
    initial begin
        repeat (4) @(posedge sys_clk_in);
        check({31'h0, reset_powerdown_n_out}, 32'h0);
        nrst_in <= 1'b1;
        t_reset();
        wait_idle();
        t_program();
        t_errors();
        t_buffer();
        t_suspend();
        t_power();
        print_verdict();
    end
endmodule : testbench
bind fps_host fps_host_checker u_fps_host_checker (.*);

// ### include/fps_pkg.sv
// Purpose: constants shared by the flash host controller
// Assumes: 20 MHz system clock, byte-wide flash data bus
// Notes: register offsets are word addresses on the software port
package fps_pkg;
    // Flash command codes
    localparam logic [7:0] FPS_CMD_PROG_SETUP = 8'h40;
    localparam logic [7:0] FPS_CMD_READ_ARRAY = 8'hff;
    localparam logic [7:0] FPS_CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] FPS_CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] FPS_CMD_SUSPEND = 8'hb0;
    localparam logic [7:0] FPS_CMD_RESUME = 8'hd0;
    localparam logic [7:0] FPS_CMD_BUF_WRITE = 8'he8;
    // Flash status bit positions
    localparam int FPS_SR_READY = 7;
    localparam int FPS_SR_SUSP = 6;
    localparam int FPS_SR_PROG_ERR = 4;
    localparam int FPS_SR_VOLT_ERR = 3;
    localparam int FPS_SR_PROT_ERR = 1;
    localparam int FPS_XSR_BUF_AVAIL = 7;
    // Mask that drops reserved status bits 2 and 0
    localparam logic [7:0] FPS_SR_KEEP = 8'hfa;
    // Mask that drops reserved extended bits 6..0
    localparam logic [7:0] FPS_XSR_KEEP = 8'h80;
    // Software register offsets
    localparam logic [3:0] FPS_REG_CTRL = 4'h0;
    localparam logic [3:0] FPS_REG_ADDR = 4'h1;
    localparam logic [3:0] FPS_REG_WDATA = 4'h2;
    localparam logic [3:0] FPS_REG_STATUS = 4'h3;
    localparam logic [3:0] FPS_REG_RDATA = 4'h4;
    localparam logic [3:0] FPS_REG_IRQ_STAT = 4'h5;
    localparam logic [3:0] FPS_REG_IRQ_MASK = 4'h6;
    localparam logic [3:0] FPS_REG_POWER = 4'h7;
    // Control register operation codes
    localparam logic [2:0] FPS_OP_PROGRAM = 3'h1;
    localparam logic [2:0] FPS_OP_READ = 3'h2;
    localparam logic [2:0] FPS_OP_CLEAR = 3'h3;
    localparam logic [2:0] FPS_OP_SUSPEND = 3'h4;
    localparam logic [2:0] FPS_OP_RESUME = 3'h5;
    localparam logic [2:0] FPS_OP_BUF_QUERY = 3'h6;
    // Interrupt bit positions
    localparam int FPS_IRQ_DONE = 0;
    localparam int FPS_IRQ_ERROR = 1;
    localparam int FPS_IRQ_SUSP = 2;
    // Bus timing, 50 ns per cycle
    localparam int FPS_CLK_NS = 50;
    localparam int FPS_STROBE_NS = 100;
    localparam int FPS_STROBE_CYC = (FPS_STROBE_NS + FPS_CLK_NS - 1) / FPS_CLK_NS;
    localparam int FPS_RESET_NS = 1000;
    localparam int FPS_RESET_CYC = (FPS_RESET_NS + FPS_CLK_NS - 1) / FPS_CLK_NS;
    // Reset values
    localparam logic [7:0] FPS_MASK_RESET = 8'h00;
    localparam logic [7:0] FPS_STATUS_RESET = 8'h80;
endpackage : fps_pkg

// ### logic/fps_host.sv
// Purpose: host controller that drives a parallel flash through its pins
// Assumes: pins synchronous to sys_clk_in; software port with one-cycle read
// Notes: one flash bus cycle at a time, each strobe two cycles wide
module fps_host
    import fps_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    // Software register port
    input wire logic [3:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [31:0] reg_rdata_out,
    output logic irq_out,
    // System power indication
    input wire logic system_power_ok_in,
    // Flash pins
    output logic [23:0] flash_addr_out,
    input wire logic [7:0] flash_data_in,
    output logic [7:0] flash_data_out,
    output logic flash_data_oe_out,
    output logic chip_enable_zero_n_out,
    output logic flash_oe_n_out,
    output logic flash_we_n_out,
    output logic reset_powerdown_n_out,
    input wire logic status_pin_in
);
    // Controller states
    typedef enum logic [3:0] {
        ST_IDLE, ST_WR_CMD, ST_WR_DATA, ST_POLL, ST_TOGGLE, ST_CHECK,
        ST_RD_ARRAY_CMD, ST_RD_ARRAY, ST_RESET
    } fps_state_t;

    fps_state_t state;        // Current state
    logic [2:0] op;           // Operation in progress
    logic [23:0] addr;        // Target address register
    logic [7:0] wdata;        // Program data register
    logic [7:0] rdata;        // Last array read
    logic [7:0] flash_status; // Last masked status seen
    logic [7:0] ext_status;   // Last masked extended status
    logic [7:0] irq_stat;     // Sticky event bits
    logic [7:0] irq_mask;     // Interrupt enables
    logic err_seen;           // Error found, clear needed
    logic strobe_go;          // Start one bus strobe
    logic strobe_busy;        // Strobe in progress
    logic strobe_done;        // Last strobe cycle
    logic [4:0] rst_count;    // Reset pulse counter
    logic power_ok_q;         // Power good of last cycle
    logic cmd_phase;          // Second write pending
    logic [7:0] bus_word;     // Byte for the write strobe
    logic is_read;            // Current strobe is a read
    logic go;                 // Software start
    logic events_done, events_err, events_susp, check_exit;

    // Masks the reserved bits of a status byte
    function automatic logic [7:0] fps_keep(input logic [7:0] raw, input logic [7:0] keep);
        fps_keep = raw & keep;
    endfunction : fps_keep

    // Start of a new operation from software
    assign go = reg_write_in && (reg_addr_in == FPS_REG_CTRL) && (state == ST_IDLE)
        && (reg_wdata_in[2:0] != 3'h0);

    // Strobe timing shared by reads and writes
    fps_strobe u_strobe (
        .sys_clk_in(sys_clk_in),
        .nrst_in(nrst_in),
        .start_in(strobe_go),
        .busy_out(strobe_busy),
        .done_out(strobe_done)
    );

    // Launches a strobe on each bus-cycle state entry
    assign strobe_go = !strobe_busy && state != ST_IDLE && state != ST_CHECK
        && state != ST_RESET;

    // Read strobes versus write strobes
    assign is_read = (state == ST_POLL) || (state == ST_TOGGLE) || (state == ST_RD_ARRAY);

    // Main sequencer
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state <= ST_RESET;
            op <= 3'h0;
            cmd_phase <= 1'b0;
        end else begin
            case (state)
                ST_RESET: begin
                    if (rst_count == 5'h0 && power_ok_q) begin
                        state <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    if (!power_ok_q) begin
                        state <= ST_RESET;
                    end else if (go) begin
                        op <= reg_wdata_in[2:0];
                        cmd_phase <= 1'b0;
                        if (reg_wdata_in[2:0] == FPS_OP_READ) begin
                            state <= ST_RD_ARRAY_CMD;
                        end else begin
                            state <= ST_WR_CMD;
                        end
                    end
                end
                ST_WR_CMD: begin
                    if (strobe_done) begin
                        if (op == FPS_OP_PROGRAM) begin
                            state <= ST_WR_DATA;
                        end else if (op == FPS_OP_CLEAR) begin
                            state <= ST_IDLE;
                        end else if (op == FPS_OP_RESUME) begin
                            state <= ST_IDLE;
                        end else begin
                            state <= ST_POLL;
                        end
                    end
                end
                ST_WR_DATA: begin
                    if (strobe_done) begin
                        state <= ST_POLL;
                    end
                end
                ST_POLL, ST_TOGGLE: begin
                    if (strobe_done) begin
                        if (op == FPS_OP_BUF_QUERY) begin
                            state <= ST_IDLE;
                        end else if (flash_data_in[FPS_SR_READY]) begin
                            state <= ST_CHECK;
                        end else begin
                            state <= ST_TOGGLE;
                        end
                    end
                end
                ST_CHECK: begin
                    if (op == FPS_OP_PROGRAM && !status_pin_in) begin
                        state <= ST_TOGGLE;
                    end else begin
                        state <= ST_IDLE;
                    end
                end
                ST_RD_ARRAY_CMD: begin
                    if (strobe_done) begin
                        state <= ST_RD_ARRAY;
                    end
                end
                ST_RD_ARRAY: begin
                    if (strobe_done) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Byte placed on the data bus for each write
    always_comb begin
        bus_word = FPS_CMD_READ_ARRAY;
        if (state == ST_WR_CMD) begin
            case (op)
                FPS_OP_PROGRAM: bus_word = FPS_CMD_PROG_SETUP;
                FPS_OP_CLEAR: bus_word = FPS_CMD_CLEAR_STATUS;
                FPS_OP_SUSPEND: bus_word = FPS_CMD_SUSPEND;
                FPS_OP_RESUME: bus_word = FPS_CMD_RESUME;
                FPS_OP_BUF_QUERY: bus_word = FPS_CMD_BUF_WRITE;
                default: bus_word = FPS_CMD_READ_STATUS;
            endcase
        end else if (state == ST_WR_DATA) begin
            bus_word = wdata;
        end
    end

    // Flash pin drivers, registered
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            flash_addr_out <= 24'h0;
            flash_data_out <= 8'h00;
            flash_data_oe_out <= 1'b0;
            chip_enable_zero_n_out <= 1'b1;
            flash_oe_n_out <= 1'b1;
            flash_we_n_out <= 1'b1;
        end else begin
            flash_addr_out <= addr;
            flash_data_out <= bus_word;
            // Select and data outlive the write strobe by one cycle
            flash_data_oe_out <= strobe_busy && !is_read;
            chip_enable_zero_n_out <= !strobe_busy;
            // High-low-high pulse on each read, poll or array
            flash_oe_n_out <= !(strobe_busy && is_read && !strobe_done);
            flash_we_n_out <= !(strobe_busy && !is_read && !strobe_done);
        end
    end

    // Reset pin follows power good and reset pulse
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_count <= 5'(FPS_RESET_CYC);
            power_ok_q <= 1'b0;
            reset_powerdown_n_out <= 1'b0;
        end else begin
            power_ok_q <= system_power_ok_in;
            if (!power_ok_q) begin
                rst_count <= 5'(FPS_RESET_CYC);
            end else if (rst_count != 5'h0) begin
                rst_count <= rst_count - 5'h1;
            end
            reset_powerdown_n_out <= power_ok_q && (rst_count == 5'h0);
        end
    end

    // Captures status, array data and error state
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            flash_status <= FPS_STATUS_RESET;
            ext_status <= 8'h00;
            rdata <= 8'h00;
            err_seen <= 1'b0;
        end else begin
            if (strobe_done && (state == ST_POLL || state == ST_TOGGLE)) begin
                if (op == FPS_OP_BUF_QUERY) begin
                    ext_status <= fps_keep(flash_data_in, FPS_XSR_KEEP);
                end else begin
                    flash_status <= fps_keep(flash_data_in, FPS_SR_KEEP);
                end
            end
            if (strobe_done && state == ST_RD_ARRAY) begin
                rdata <= flash_data_in;
            end
            if (state == ST_CHECK && (flash_status[FPS_SR_PROG_ERR]
                || flash_status[FPS_SR_VOLT_ERR] || flash_status[FPS_SR_PROT_ERR])) begin
                err_seen <= 1'b1;
            end else if (state == ST_WR_CMD && op == FPS_OP_CLEAR) begin
                err_seen <= 1'b0;
            end
        end
    end

    // Event pulses on leaving the check state
    assign check_exit = (state == ST_CHECK) && !(op == FPS_OP_PROGRAM && !status_pin_in);
    // Ops that skip the check state finish on their last strobe
    assign events_done = check_exit || (strobe_done && ((state == ST_WR_CMD
        && (op == FPS_OP_CLEAR || op == FPS_OP_RESUME)) || state == ST_RD_ARRAY
        || (state == ST_POLL && op == FPS_OP_BUF_QUERY)));
    assign events_err = check_exit && (flash_status[FPS_SR_PROG_ERR]
        || flash_status[FPS_SR_VOLT_ERR] || flash_status[FPS_SR_PROT_ERR]);
    assign events_susp = check_exit && (op == FPS_OP_SUSPEND)
        && flash_status[FPS_SR_SUSP];

    // Software registers
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            addr <= 24'h0;
            wdata <= 8'h00;
            irq_mask <= FPS_MASK_RESET;
            irq_stat <= 8'h00;
        end else begin
            if (reg_write_in && reg_addr_in == FPS_REG_ADDR && state == ST_IDLE) begin
                addr <= reg_wdata_in[23:0];
            end
            if (reg_write_in && reg_addr_in == FPS_REG_WDATA && state == ST_IDLE) begin
                wdata <= reg_wdata_in[7:0];
            end
            if (reg_write_in && reg_addr_in == FPS_REG_IRQ_MASK) begin
                irq_mask <= reg_wdata_in[7:0];
            end
            // Set wins over write-one-to-clear
            for (int i = 0; i < 8; i++) begin
                if ((i == FPS_IRQ_DONE && events_done) || (i == FPS_IRQ_ERROR && events_err)
                    || (i == FPS_IRQ_SUSP && events_susp)) begin
                    irq_stat[i] <= 1'b1;
                end else if (reg_write_in && reg_addr_in == FPS_REG_IRQ_STAT
                    && reg_wdata_in[i]) begin
                    irq_stat[i] <= 1'b0;
                end
            end
        end
    end

    // Read data one cycle after the read strobe
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            reg_rdata_out <= 32'h0;
        end else if (reg_read_in) begin
            if (reg_addr_in == FPS_REG_CTRL) begin
                reg_rdata_out <= {28'h0, (state == ST_IDLE), op};
            end else if (reg_addr_in == FPS_REG_ADDR) begin
                reg_rdata_out <= {8'h0, addr};
            end else if (reg_addr_in == FPS_REG_WDATA) begin
                reg_rdata_out <= {24'h0, wdata};
            end else if (reg_addr_in == FPS_REG_STATUS) begin
                reg_rdata_out <= {15'h0, err_seen, ext_status, flash_status};
            end else if (reg_addr_in == FPS_REG_RDATA) begin
                reg_rdata_out <= {24'h0, rdata};
            end else if (reg_addr_in == FPS_REG_IRQ_STAT) begin
                reg_rdata_out <= {24'h0, irq_stat};
            end else if (reg_addr_in == FPS_REG_IRQ_MASK) begin
                reg_rdata_out <= {24'h0, irq_mask};
            end else if (reg_addr_in == FPS_REG_POWER) begin
                reg_rdata_out <= {30'h0, status_pin_in, reset_powerdown_n_out};
            end else begin
                reg_rdata_out <= 32'h0;
            end
        end else begin
            reg_rdata_out <= 32'h0;
        end
    end

    // Level interrupt from unmasked sticky bits
    assign irq_out = |(irq_stat & irq_mask);
endmodule : fps_host

// ### logic/fps_strobe.sv
// Purpose: timed strobe generator for flash bus cycles
// Assumes: start is a one-cycle pulse while idle
// Notes: busy holds for a fixed count of cycles after start
module fps_strobe
    import fps_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic start_in,
    output logic busy_out,
    output logic done_out
);
    // Cycle counter of the active strobe
    logic [3:0] count;

    // Counts the strobe width plus one release cycle
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            count <= 4'h0;
        end else if (start_in) begin
            count <= 4'(FPS_STROBE_CYC + 1);
        end else if (count != 4'h0) begin
            count <= count - 4'h1;
        end
    end

    assign busy_out = (count != 4'h0);
    assign done_out = (count == 4'h1);
endmodule : fps_strobe
